// >>> core/cmi_crtc.sv
// top of the crt memory access, interlace and skew block
// assumes characterClock and phaseTwo are asynchronous pins
//
// Added by the designer: the address-and-strobe port and the register addresses.
`default_nettype none
module cmi_crtc
  import cmi_pkg::*;
(
  input  wire logic        clock,          // 200 MHz system clock
  input  wire logic        reset_n,        // sync reset, active low
  input  wire logic [4:0]  regAddr,        // register index
  input  wire logic [7:0]  regWrData,      // write data
  input  wire logic        regWrite,       // write strobe
  input  wire logic        regRead,        // read strobe
  output logic      [7:0]  regRdData,      // read data, next cycle
  input  wire logic        characterClock, // character clock pin
  input  wire logic        phaseTwo,       // host phase-two pin
  output logic      [13:0] memoryAddress,  // display ram address lines
  output logic      [4:0]  rowAddress,     // row lines, bit 4 is strobe in blanking mode
  output logic             displayEnable,  // display enable
  output logic             cursor,         // cursor output
  output logic             hSync,          // horizontal sync
  output logic             vSync           // vertical sync
);
  import cmi_pkg::*;
  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [1:0] cclkSync_q, phiSync_q;
  logic       cclkLast_q;
  logic       charTick;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cclkSync_q <= 2'b00;
      phiSync_q  <= 2'b00;
      cclkLast_q <= 1'b0;
    end else begin
      cclkSync_q <= {cclkSync_q[0], characterClock};
      phiSync_q  <= {phiSync_q[0], phaseTwo};
      cclkLast_q <= cclkSync_q[1];
    end
  end
  assign charTick = cclkSync_q[1] & ~cclkLast_q;
  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic [7:0]  hTotal_q, mode_q;
  logic [6:0]  vTotal_q, vDisp_q, vSyncPos_q;
  logic [4:0]  scanLines_q;
  logic [13:0] cursorPos_q, updAddr_q;
  logic        updReady_q;
  logic        dummyHit, updDone;
  logic [1:0]  intl;
  assign intl = {mode_q[INTL_HI_BIT], mode_q[INTL_LO_BIT]};
  // a read or write of the dummy location counts as a transparent access
  assign dummyHit = (regWrite | regRead) && (regAddr == DUMMY_OFF);
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hTotal_q    <= HTOTAL_RST;
      vTotal_q    <= VTOTAL_RST;
      vDisp_q     <= VDISP_RST;
      vSyncPos_q  <= VSYNC_RST;
      scanLines_q <= SCANL_RST;
      mode_q      <= MODE_RST;
      cursorPos_q <= 14'h0000;
    end else if (regWrite) begin
      case (regAddr)
        HTOTAL_OFF: hTotal_q    <= regWrData;
        VTOTAL_OFF: vTotal_q    <= regWrData[6:0];
        VDISP_OFF:  vDisp_q     <= regWrData[6:0];
        VSYNC_OFF:  vSyncPos_q  <= regWrData[6:0];
        MODE_OFF:   mode_q      <= regWrData;
        SCANL_OFF:  scanLines_q <= regWrData[4:0];
        CURSH_OFF:  cursorPos_q[13:8] <= regWrData[5:0];
        CURSL_OFF:  cursorPos_q[7:0]  <= regWrData;
        default: ;
      endcase
    end
  end
  // update address: host loads, hardware steps after each access
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      updAddr_q <= 14'h0000;
    end else if (regWrite && regAddr == UPDH_OFF) begin
      updAddr_q[13:8] <= regWrData[5:0];
    end else if (regWrite && regAddr == UPDL_OFF) begin
      updAddr_q[7:0] <= regWrData;
    end else if (updDone) begin
      updAddr_q <= cmiNextAddr(updAddr_q, mode_q[ROWCOL_BIT]);
    end
  end
  // --------------------------------------------------------------
  // update state machine
  // --------------------------------------------------------------
  cmi_upd_e updState_q;
  logic     inBlank, phiHigh;
  assign phiHigh = phiSync_q[1];
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      updState_q <= CMI_IDLE;
    end else begin
      case (updState_q)
        CMI_IDLE:  if (dummyHit && mode_q[TRANSP_BIT]) begin
                     updState_q <= CMI_WAIT;
                   end
        // blanking mode waits for retrace, interleave waits for phase two
        CMI_WAIT:  if (mode_q[UPDBLANK_BIT] ? inBlank : phiHigh) begin
                     updState_q <= CMI_DRIVE;
                   end
        CMI_DRIVE: if (charTick || !mode_q[UPDBLANK_BIT]) begin
                     updState_q <= CMI_IDLE;
                   end
        default:   updState_q <= CMI_IDLE;
      endcase
    end
  end
  assign updDone = (updState_q == CMI_DRIVE) &&
                   (charTick || !mode_q[UPDBLANK_BIT]);
  // set wins over the clear by a status read
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      updReady_q <= 1'b0;
    end else if (updDone) begin
      updReady_q <= 1'b1;
    end else if (regRead && regAddr == STATUS_OFF) begin
      updReady_q <= 1'b0;
    end
  end
  // --------------------------------------------------------------
  // raster counters
  // --------------------------------------------------------------
  logic [7:0]  hCnt_q;
  logic [4:0]  scan_q, vsLeft_q;
  logic [6:0]  row_q;
  logic [13:0] rowBase_q, chAddr_q;
  logic        field_q, halfPend_q;
  logic        lineEnd, rowEnd, fieldEnd, hBlank, vBlank;
  logic [4:0]  scanEff;
  assign lineEnd  = charTick && (hCnt_q == hTotal_q);
  assign rowEnd   = lineEnd && (scan_q >= scanLines_q);
  // >= so that a smaller total written mid-field cannot run the rows around
  assign fieldEnd = rowEnd && (row_q >= vTotal_q);
  assign hBlank   = hCnt_q > 8'h4F;
  assign vBlank   = row_q >= vDisp_q;
  assign inBlank  = hBlank | vBlank;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hCnt_q <= 8'h00;
      scan_q <= 5'h00;
      row_q  <= 7'h00;
    end else if (charTick) begin
      hCnt_q <= lineEnd ? 8'h00 : 8'(hCnt_q + 8'h01);
      if (lineEnd) begin
        // sync-and-video mode steps the scan count by two per line
        scan_q <= rowEnd ? 5'h00 :
                  5'(scan_q + ((intl == INTL_VIDEO) ? 5'h02 : 5'h01));
        if (rowEnd) begin
          row_q <= fieldEnd ? 7'h00 : 7'(row_q + 7'h01);
        end
      end
    end
  end
  // field parity picks vsync delay and odd/even lines
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      field_q <= 1'b0;
    end else if (fieldEnd) begin
      field_q <= ~field_q;
    end
  end
  assign scanEff = (intl == INTL_VIDEO) ? (scan_q | {4'h0, field_q}) :
                   scan_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rowBase_q <= 14'h0000;
      chAddr_q  <= 14'h0000;
    end else if (charTick) begin
      if (fieldEnd) begin
        rowBase_q <= 14'h0000;
        chAddr_q  <= 14'h0000;
      end else if (rowEnd) begin
        rowBase_q <= mode_q[ROWCOL_BIT] ?
                     {6'(rowBase_q[13:8] + 6'h01), 8'h00} :
                     14'(rowBase_q + 14'h0050);
        chAddr_q  <= mode_q[ROWCOL_BIT] ?
                     {6'(rowBase_q[13:8] + 6'h01), 8'h00} :
                     14'(rowBase_q + 14'h0050);
      end else if (lineEnd) begin
        chAddr_q <= rowBase_q;
      end else begin
        chAddr_q <= cmiNextAddr(chAddr_q, mode_q[ROWCOL_BIT]);
      end
    end
  end
  // vsync: half-line delay in odd fields of interlaced modes
  logic       vsStart;
  logic [7:0] halfPt;
  // odd total means total + 1 characters, so half a line is (total + 1) / 2
  assign halfPt  = 8'(({1'b0, hTotal_q} + 9'h001) >> 1);
  assign vsStart = charTick && (scan_q == 5'h00) && (row_q == vSyncPos_q);
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      vsLeft_q   <= 5'h00;
      halfPend_q <= 1'b0;
    end else if (vsStart && hCnt_q == 8'h00) begin
      if (intl[0] && field_q) begin
        halfPend_q <= 1'b1;
      end else begin
        vsLeft_q <= VSYNC_LEN;
      end
    end else if (halfPend_q && charTick &&
                 hCnt_q == halfPt) begin
      halfPend_q <= 1'b0;
      vsLeft_q   <= VSYNC_LEN;
    end else if (charTick && hCnt_q == halfPt &&
                 vsLeft_q != 5'h00) begin
      vsLeft_q <= 5'(vsLeft_q - 5'h01);
    end
  end
  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  cmi_skew_if skIf();
  assign skIf.rawDe     = ~inBlank;
  assign skIf.rawCursor = ~inBlank && (chAddr_q == cursorPos_q);
  assign skIf.deSkewEn  = mode_q[DESKEW_BIT];
  assign skIf.curSkewEn = mode_q[CSKEW_BIT];
  cmi_skew uSkew (
    .clock    (clock),
    .reset_n  (reset_n),
    .charTick (charTick),
    .sk       (skIf.skew)
  );
  logic        driveUpd;
  logic [13:0] maD;
  assign driveUpd = mode_q[TRANSP_BIT] &&
    (mode_q[UPDBLANK_BIT] ? (updState_q == CMI_DRIVE && inBlank)
                          : phiHigh);
  assign maD = driveUpd ? updAddr_q : chAddr_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      memoryAddress <= 14'h0000;
      rowAddress    <= 5'h00;
      hSync         <= 1'b0;
      vSync         <= 1'b0;
      regRdData     <= 8'h00;
    end else begin
      memoryAddress <= maD;
      rowAddress    <= {mode_q[UPDBLANK_BIT] ? driveUpd : scanEff[4],
                        scanEff[3:0]};
      hSync         <= hCnt_q == 8'h52;
      vSync         <= vsLeft_q != 5'h00;
      regRdData     <= 8'h00;
      if (regRead) begin
        case (regAddr)
          STATUS_OFF: begin
            regRdData[UPDRDY_BIT] <= updReady_q;
            regRdData[VRETR_BIT]  <= vBlank;
          end
          CURSH_OFF: regRdData <= {2'b00, cursorPos_q[13:8]};
          CURSL_OFF: regRdData <= cursorPos_q[7:0];
          default:   regRdData <= 8'h00;
        endcase
      end
    end
  end
  assign displayEnable = skIf.outDe;
  assign cursor        = skIf.outCursor;
endmodule
`default_nettype wire

// >>> core/cmi_pkg.sv
// cmi_pkg: constants shared by the crt memory access / interlace / skew block
// assumes a single 200 MHz system clock domain
`default_nettype none
package cmi_pkg;
  // ---------------------------------------------------------------
  // register bus offsets (register index on the address port)
  // ---------------------------------------------------------------
  localparam logic [4:0] HTOTAL_OFF  = 5'h00;
  localparam logic [4:0] VTOTAL_OFF  = 5'h04;
  localparam logic [4:0] VDISP_OFF   = 5'h06;
  localparam logic [4:0] VSYNC_OFF   = 5'h07;
  localparam logic [4:0] MODE_OFF    = 5'h08;
  localparam logic [4:0] SCANL_OFF   = 5'h09;
  localparam logic [4:0] CURSH_OFF   = 5'h0E;
  localparam logic [4:0] CURSL_OFF   = 5'h0F;
  localparam logic [4:0] UPDH_OFF    = 5'h12;
  localparam logic [4:0] UPDL_OFF    = 5'h13;
  localparam logic [4:0] STATUS_OFF  = 5'h1E;
  localparam logic [4:0] DUMMY_OFF   = 5'h1F;
  // ---------------------------------------------------------------
  // mode control fields
  // ---------------------------------------------------------------
  localparam int INTL_LO_BIT  = 0;
  localparam int INTL_HI_BIT  = 1;
  localparam int ROWCOL_BIT   = 2;
  localparam int TRANSP_BIT   = 3;
  localparam int DESKEW_BIT   = 4;
  localparam int CSKEW_BIT    = 5;
  localparam int UPDBLANK_BIT = 6;
  // status fields
  localparam int UPDRDY_BIT   = 7;
  localparam int VRETR_BIT    = 5;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] HTOTAL_RST = 8'h0F;
  localparam logic [6:0] VTOTAL_RST = 7'h07;
  localparam logic [6:0] VDISP_RST  = 7'h04;
  localparam logic [6:0] VSYNC_RST  = 7'h05;
  localparam logic [4:0] SCANL_RST  = 5'h03;
  localparam logic [7:0] MODE_RST   = 8'h00;
  // interlace field
  localparam logic [1:0] INTL_SYNC  = 2'h1;
  localparam logic [1:0] INTL_VIDEO = 2'h3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int VSYNC_LINES = 3;
  localparam logic [4:0] VSYNC_LEN = 5'(VSYNC_LINES);
  typedef enum logic [2:0] {
    CMI_IDLE  = 3'b001,
    CMI_WAIT  = 3'b010,
    CMI_DRIVE = 3'b100
  } cmi_upd_e;
  // 14-bit address step honouring row/column format
  function automatic logic [13:0] cmiNextAddr(input logic [13:0] a,
                                              input logic rowCol);
    logic [13:0] r;
    r = a + 14'h0001;
    if (rowCol && (a[7:0] == 8'hFF)) begin
      r = {6'(a[13:8] + 6'h01), 8'h00};
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// >>> core/cmi_skew.sv
// cmi_skew: one character-clock delay stage for display enable and cursor
// assumes charTick pulses once per character clock rising edge
`default_nettype none
module cmi_skew (
  input wire logic clock,    // system clock
  input wire logic reset_n,  // sync reset, active low
  input wire logic charTick, // one-cycle character strobe
  cmi_skew_if.skew sk        // raw and skewed signals
);
  logic deDly_q;
  logic curDly_q;
  logic outDe_q;
  logic outCur_q;
  // --------------------------------------------------------------
  // delay stages, bypassed when skew is off
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      deDly_q  <= 1'b0;
      curDly_q <= 1'b0;
    end else if (charTick) begin
      deDly_q  <= sk.rawDe;
      curDly_q <= sk.rawCursor;
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      outDe_q  <= 1'b0;
      outCur_q <= 1'b0;
    end else begin
      outDe_q  <= sk.deSkewEn ? deDly_q : sk.rawDe;
      outCur_q <= sk.curSkewEn ? curDly_q : sk.rawCursor;
    end
  end
  assign sk.outDe     = outDe_q;
  assign sk.outCursor = outCur_q;
endmodule
`default_nettype wire

// >>> core/cmi_skew_if.sv
// cmi_skew_if: display enable / cursor pair handed to the skew stage
// assumes both ends run on the system clock
`default_nettype none
interface cmi_skew_if;
  logic rawDe;
  logic rawCursor;
  logic deSkewEn;
  logic curSkewEn;
  logic outDe;
  logic outCursor;
  modport core (output rawDe, rawCursor, deSkewEn, curSkewEn,
                input outDe, outCursor);
  modport skew (input rawDe, rawCursor, deSkewEn, curSkewEn,
                output outDe, outCursor);
endinterface
`default_nettype wire

// >>> verification/cmi_crtc_asserts.sv
// cmi_crtc_asserts: port-level checks for the crt access block
// assumes a single clock domain; bound to every cmi_crtc instance
`default_nettype none
module cmi_crtc_asserts
  import cmi_pkg::*;
(
  input wire logic        clock,          // system clock
  input wire logic        reset_n,        // sync reset, active low
  input wire logic [4:0]  regAddr,        // register index
  input wire logic [7:0]  regWrData,      // write data
  input wire logic        regWrite,       // write strobe
  input wire logic        regRead,        // read strobe
  input wire logic [7:0]  regRdData,      // read data
  input wire logic        characterClock, // character clock pin
  input wire logic        phaseTwo,       // host phase-two pin
  input wire logic [13:0] memoryAddress,  // display ram address
  input wire logic [4:0]  rowAddress,     // row lines and strobe
  input wire logic        displayEnable,  // display enable
  input wire logic        cursor,         // cursor
  input wire logic        hSync,          // horizontal sync
  input wire logic        vSync           // vertical sync
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // shadow of written registers
  // ---------------------------------------------------------------
  logic [7:0] modeQ;
  logic [5:0] cursHQ;
  logic [7:0] cursLQ;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      modeQ <= MODE_RST;
    end else if (regWrite && regAddr == MODE_OFF) begin
      modeQ <= regWrData;
    end
  end
  always_ff @(posedge clock) begin
    if (regWrite && regAddr == CURSH_OFF) begin
      cursHQ <= regWrData[5:0];
    end
    if (regWrite && regAddr == CURSL_OFF) begin
      cursLQ <= regWrData;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence rdAt(a);
    regRead && regAddr == a;
  endsequence
  sequence rdyShown;
    rdAt(STATUS_OFF) ##1 (rdAt(STATUS_OFF) && regRdData[UPDRDY_BIT]);
  endsequence
  AST_RD_ONE_CYCLE: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data outside its cycle");
  AST_STATUS_SPARE: assert property (rdAt(STATUS_OFF) |=>
    regRdData[6] == 1'b0 && regRdData[4:0] == 5'h00)
    else $error("status spare bits set");
  AST_UNMAPPED_ZERO: assert property (regRead &&
    regAddr inside {5'h10, 5'h11, 5'h1C} |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_CURSL_RB: assert property (rdAt(CURSL_OFF) |=>
    regRdData == $past(cursLQ))
    else $error("cursor low readback wrong");
  AST_CURSH_RB: assert property (rdAt(CURSH_OFF) |=>
    regRdData == {2'b00, $past(cursHQ)})
    else $error("cursor high readback wrong");
  AST_RESET_QUIET: assert property ($rose(reset_n) |->
    memoryAddress == 14'h0000 && rowAddress == 5'h00 && !cursor &&
    !displayEnable && !hSync && !vSync && regRdData == 8'h00)
    else $error("outputs active straight after reset");
  AST_UPDRDY_CLEAR: assert property (rdyShown |=>
    !regRdData[UPDRDY_BIT])
    else $error("update ready not cleared by status read");
  AST_VRETR_IN_VSYNC: assert property (rdAt(STATUS_OFF) && vSync |=>
    regRdData[VRETR_BIT])
    else $error("retrace bit low during vertical sync");
  AST_VSYNC_BLANK: assert property (vSync |-> !displayEnable)
    else $error("display enable during vertical sync");
  AST_STB_BLANK: assert property (rowAddress[4] &&
    modeQ[UPDBLANK_BIT] && !modeQ[DESKEW_BIT] |-> !displayEnable)
    else $error("update strobe outside blanking");
endmodule

bind cmi_crtc cmi_crtc_asserts u_chk (
  .clock(clock), .reset_n(reset_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .characterClock(characterClock),
  .phaseTwo(phaseTwo), .memoryAddress(memoryAddress),
  .rowAddress(rowAddress), .displayEnable(displayEnable),
  .cursor(cursor), .hSync(hSync), .vSync(vSync));
`default_nettype wire

// >>> verification/cmi_far_end.sv
// cmi_far_end: character clock source, host phase two and ram mux
// assumes the bench gates phase two and supplies a host address
`default_nettype none
module cmi_far_end (
  input  wire logic        runP2,         // let phase two toggle
  input  wire logic [13:0] hostAddr,      // host side address
  input  wire logic [13:0] memoryAddress, // device address lines
  output logic             charClk,       // character clock, 80 ns
  output logic             phase2,        // host phase two
  output logic      [13:0] ramAddr        // address at the ram
);
  timeunit 1ns;
  timeprecision 100ps;
  initial charClk = 1'b0;
  always #40 charClk = ~charClk;
  // phase two rests low while the host bus is idle
  initial phase2 = 1'b0;
  always #100 phase2 = runP2 ? ~phase2 : 1'b0;
  // device owns the ram in phase one, host wins in phase two
  assign ramAddr = phase2 ? hostAddr : memoryAddress;
endmodule
`default_nettype wire

// >>> verification/tb_cmi_crtc.sv
// tb_cmi_crtc: self-checking bench for the crt access block
// assumes cmi_far_end makes the character clock and phase two
`default_nettype none
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_cmi_crtc;
  timeunit 1ns;
  timeprecision 100ps;
  import cmi_pkg::*;
  localparam int CPC = 16;
  localparam int HALF = (int'(HTOTAL_RST) + 1) * CPC / 2;
  localparam int FRAME = (int'(VTOTAL_RST) + 1) * (int'(SCANL_RST) + 1)
                         * HALF * 2;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  regAddr = 5'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        runP2 = 1'b0;
  logic [13:0] hostAddr = 14'h0000;
  logic [7:0]  regRdData;
  logic        charClk, phase2, displayEnable, cursor, hSync, vSync;
  logic [13:0] memoryAddress;
  logic [4:0]  rowAddress;
  logic [7:0]  expQ[$];
  logic [7:0]  mskQ[$];
  logic [7:0]  eV, mV;
  logic        rdSeen = 1'b0;
  int          error_cnt = 0;
  int          cmp_count = 0;
  wire logic [3:0] obs = {vSync, cursor, displayEnable, rowAddress[4]};
  always #2.5 clock = ~clock;
  cmi_crtc dut (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .characterClock(charClk),
    .phaseTwo(phase2), .memoryAddress(memoryAddress),
    .rowAddress(rowAddress), .displayEnable(displayEnable),
    .cursor(cursor), .hSync(hSync), .vSync(vSync));
  cmi_far_end far (.runP2(runP2), .hostAddr(hostAddr),
    .memoryAddress(memoryAddress), .charClk(charClk),
    .phase2(phase2), .ramAddr());
  // ---------------------------------------------------------------
  // bus tasks and read scoreboard
  // ---------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // twice: a second read follows at once and must see ready cleared
  task automatic rd(input logic [4:0] a, input logic [7:0] e,
                    input logic [7:0] m, input bit twice);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    mskQ.push_back(m);
    if (twice) begin
      expQ.push_back(8'h00);
      mskQ.push_back(8'h80);
      @(posedge clock);
    end
    @(posedge clock);
    regRead <= 1'b0;
  endtask
  always @(posedge clock) begin
    if (rdSeen && expQ.size() > 0) begin
      eV = expQ.pop_front();
      mV = mskQ.pop_front();
      `CHK("read data", eV, regRdData & mV)
    end
    rdSeen <= regRead;
  end
  task automatic waitFor(input int i, input logic lv, output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (obs[i] !== lv && n < 20000);
    if (n >= 20000) `CHK("output wait", lv, obs[i])
  endtask
  task automatic edgeMa(input int i, output logic [13:0] ma);
    int n;
    waitFor(i, 1'b0, n);
    waitFor(i, 1'b1, n);
    ma = memoryAddress;
  endtask
  task automatic hitMa(input logic [13:0] a);
    int n;
    n = 0;
    while (memoryAddress !== a && n < 400) begin
      @(posedge clock);
      n++;
    end
    `CHK("update address", a, memoryAddress)
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    close_out();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    int g1, g2, n;
    logic [13:0] ua, deP, deS, cuP, cuS;
    logic [7:0] cv;
    void'($urandom(32'hd8db4655));
    hostAddr <= 14'($urandom);
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    wr(HTOTAL_OFF, HTOTAL_RST);
    cv = 8'($urandom);
    wr(CURSL_OFF, cv);
    rd(CURSL_OFF, cv, 8'hFF, 1'b0);
    wr(CURSH_OFF, ~cv);
    rd(CURSH_OFF, {2'b00, ~cv[5:0]}, 8'hFF, 1'b0);
    rd(5'h10, 8'h00, 8'hFF, 1'b0);
    rd(STATUS_OFF, 8'h00, 8'hDF, 1'b0);
    $display("registers done");
    ua = {2'b10, 12'($urandom)};
    wr(MODE_OFF, 8'h08);
    wr(UPDH_OFF, {2'b00, ua[13:8]});
    wr(UPDL_OFF, ua[7:0]);
    wr(DUMMY_OFF, 8'h00);
    runP2 <= 1'b1;
    hitMa(ua);
    rd(STATUS_OFF, 8'h80, 8'h80, 1'b1);
    wr(DUMMY_OFF, 8'h00);
    hitMa(ua + 14'h0001);
    runP2 <= 1'b0;
    $display("interleave update done");
    ua = {2'b11, 12'($urandom)};
    wr(MODE_OFF, 8'h48);
    wr(UPDH_OFF, {2'b00, ua[13:8]});
    wr(UPDL_OFF, ua[7:0]);
    rd(DUMMY_OFF, 8'h00, 8'h00, 1'b0);
    waitFor(0, 1'b1, n);
    `CHK("strobe address", ua, memoryAddress)
    `CHK("strobe blank", 1'b0, displayEnable)
    repeat (2 * CPC) @(posedge clock);
    rd(STATUS_OFF, 8'h80, 8'h80, 1'b0);
    $display("blanking update done");
    wr(MODE_OFF, 8'h00);
    wr(CURSH_OFF, 8'h00);
    wr(CURSL_OFF, 8'h05);
    edgeMa(1, deP);
    rd(STATUS_OFF, 8'h00, 8'h20, 1'b0);
    edgeMa(2, cuP);
    wr(MODE_OFF, 8'h30);
    edgeMa(1, deS);
    edgeMa(2, cuS);
    `CHK("enable skew", deP + 14'h0001, deS)
    `CHK("cursor skew", cuP + 14'h0001, cuS)
    $display("skew done");
    wr(MODE_OFF, {6'h00, INTL_SYNC});
    waitFor(3, 1'b0, n);
    waitFor(3, 1'b1, n);
    rd(STATUS_OFF, 8'h20, 8'h20, 1'b0);
    waitFor(3, 1'b0, n);
    g1 = n + 2;
    waitFor(3, 1'b1, n);
    g1 += n;
    waitFor(3, 1'b0, n);
    g2 = n;
    waitFor(3, 1'b1, n);
    g2 += n;
    `CHK("field pair length", 2 * FRAME, g1 + g2)
    `CHK("half line shift", 2 * HALF, (g1 > g2) ? g1 - g2 : g2 - g1)
    $display("interlace done");
    wr(VTOTAL_OFF, 8'h03);
    wr(VDISP_OFF, 8'h02);
    wr(VSYNC_OFF, 8'h02);
    wr(SCANL_OFF, 8'h03);
    wr(MODE_OFF, {6'h00, INTL_VIDEO});
    waitFor(1, 1'b0, n);
    waitFor(1, 1'b1, n);
    cv[0] = rowAddress[0];
    waitFor(1, 1'b0, n);
    waitFor(1, 1'b1, n);
    `CHK("field line parity", ~cv[0], rowAddress[0])
    $display("interlace video done");
    repeat (4) @(posedge clock);
    close_out();
  end
endmodule
`default_nettype wire
